// ===== rtl/gfs_status_regs.sv
// fault status register bank with read port and summary outputs
`timescale 1ns/1ps
module gfs_status_regs
   import gfs_pkg::*;
#(
   parameter int BRIDGES = 8
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [15:0] gate_fault_in,
   input wire logic [15:0] ds_fault_in,
   input wire logic main_supply_undervoltage,
   input wire logic main_supply_overvoltage,
   input wire logic charge_pump_undervoltage,
   input wire logic overtemp_warning,
   input wire logic overtemp_shutdown,
   input wire logic watchdog_fault,
   input wire logic other_warning,
   input wire logic frame_end,
   input wire logic [7:0] frame_clock_count,
   input wire logic flag_clear,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [5:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic fault_out_n,
   output logic any_fet_fault,
   output logic thermal_watchdog_summary,
   output logic link_ok
);
   // only the four and eight bridge variants exist
   if (BRIDGES != 4 && BRIDGES != 8)
   begin : g_bad_bridges
      $error("BRIDGES must be 4 or 8");
   end

   logic [7:0] gate_1_4;
   logic [7:0] gate_5_8;
   logic [7:0] supply;
   logic frame_seen;
   wire logic frame_bad;
   wire logic [7:0] supply_set;
   wire logic [15:0] gate_set;
   wire logic [7:0] next_rd;
   wire logic [7:0] global_view;
   wire logic [3:0] variant_code;
   wire logic fault_any;

   assign variant_code = (BRIDGES == 8) ? GFS_CODE_EIGHT : GFS_CODE_FOUR;
   assign frame_bad = frame_end
      && (frame_clock_count != 8'(GFS_FRAME_CLOCKS));
   assign gate_set = (BRIDGES == 8) ? gate_fault_in
      : {gate_fault_in[15:8], 8'h00};
   assign supply_set = {main_supply_undervoltage, main_supply_overvoltage,
      charge_pump_undervoltage, overtemp_warning, overtemp_shutdown,
      watchdog_fault, frame_bad, 1'b0};

   // pin fault excludes the frame length flag
   assign fault_any = (|gate_1_4) || (|gate_5_8) || (|ds_fault_in)
      || supply[GFS_BIT_SUPPLY_UV] || supply[GFS_BIT_SUPPLY_OV]
      || supply[GFS_BIT_PUMP_UV] || supply[GFS_BIT_TEMP_STOP]
      || supply[GFS_BIT_WD];
   assign global_view = {~frame_seen, 1'b0, fault_any, other_warning,
      (|gate_1_4) || (|gate_5_8) || (|ds_fault_in),
      supply[GFS_BIT_SUPPLY_UV], supply[GFS_BIT_SUPPLY_OV],
      supply[GFS_BIT_TEMP_WARN] || supply[GFS_BIT_TEMP_STOP]
         || supply[GFS_BIT_WD] || other_warning};
   assign next_rd = (addr == GFS_ADDR_GATE_1_4) ? gate_1_4 :
      (addr == GFS_ADDR_GATE_5_8) ? gate_5_8 :
      (addr == GFS_ADDR_SUPPLY) ? supply :
      (addr == GFS_ADDR_VARIANT) ? {GFS_RESERVED_HI, variant_code} :
      (addr == GFS_ADDR_GLOBAL) ? global_view : 8'h00;

   // sticky flags: a set in the clear cycle wins; writes ignored
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         gate_1_4 <= GFS_STATUS_RESET;
         gate_5_8 <= GFS_STATUS_RESET;
         supply <= GFS_STATUS_RESET;
         frame_seen <= 1'b0;
      end
      else if (clk_en)
      begin
         gate_1_4 <= (flag_clear ? 8'h00 : gate_1_4) | gate_set[15:8];
         gate_5_8 <= (flag_clear ? 8'h00 : gate_5_8) | gate_set[7:0];
         supply <= (flag_clear ? 8'h00 : supply) | supply_set;
         frame_seen <= (flag_clear ? 1'b0 : frame_seen) | frame_bad;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rd_data <= 8'h00;
         fault_out_n <= 1'b1;
         any_fet_fault <= 1'b0;
         thermal_watchdog_summary <= 1'b0;
         link_ok <= 1'b1;
      end
      else if (clk_en)
      begin
         if (rd_en)
            rd_data <= next_rd;
         fault_out_n <= ~fault_any;
         any_fet_fault <= global_view[GFS_BIT_ANY_FET];
         thermal_watchdog_summary <= global_view[GFS_BIT_THERM_WD];
         link_ok <= global_view[GFS_BIT_LINK_OK];
      end
   end

   // a frame of the wrong length seen while running
   sequence s_frame_fault;
      clk_en && frame_bad;
   endsequence

   a_frame_flag_set: assert property (@(posedge ref_clk) disable iff (reset)
      s_frame_fault |=> supply[GFS_BIT_FRAME])
      else $error("frame fault not latched");
   a_frame_no_pin: assert property (@(posedge ref_clk) disable iff (reset)
      s_frame_fault and !fault_any |=> fault_out_n)
      else $error("frame fault reached fault pin");
   a_link_ok_low: assert property (@(posedge ref_clk) disable iff (reset)
      s_frame_fault ##1 clk_en |=> !link_ok)
      else $error("link ok not cleared");
   a_variant_read: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && rd_en && addr == GFS_ADDR_VARIANT
      |=> rd_data == {GFS_RESERVED_HI, variant_code})
      else $error("variant read wrong");
   a_write_ignored: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && wr_en && !flag_clear && gate_set == 16'h0000
      && supply_set == 8'h00 |=> $stable(gate_1_4) && $stable(supply))
      else $error("write altered status");
   a_gate_latch: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && gate_fault_in[15] |=> gate_1_4[7])
      else $error("gate fault high 1 lost");
   a_supply_uv: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && main_supply_undervoltage |=> supply[GFS_BIT_SUPPLY_UV])
      else $error("undervoltage lost");
   a_fet_summary: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && (|ds_fault_in) |=> any_fet_fault)
      else $error("fet summary missing");

   a_gate_low_4: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && gate_fault_in[8] |=> gate_1_4[0])
      else $error("gate fault low 4 lost");

   a_gate_high_5: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && gate_fault_in[7] && BRIDGES == 8 |=> gate_5_8[7])
      else $error("gate fault high 5 lost");

   a_gate_low_8: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && gate_fault_in[0] && BRIDGES == 8 |=> gate_5_8[0])
      else $error("gate fault low 8 lost");

   a_four_ignore: assert property (@(posedge ref_clk) disable iff (reset)
      BRIDGES == 4 |-> gate_5_8 == 8'h00)
      else $error("absent bridges flagged");

   a_supply_ov: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && main_supply_overvoltage |=> supply[GFS_BIT_SUPPLY_OV])
      else $error("overvoltage lost");

   a_pump_uv: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && charge_pump_undervoltage |=> supply[GFS_BIT_PUMP_UV])
      else $error("pump undervoltage lost");

   a_temp_warn: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && overtemp_warning |=> supply[GFS_BIT_TEMP_WARN])
      else $error("temperature warning lost");

   a_temp_stop: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && overtemp_shutdown |=> supply[GFS_BIT_TEMP_STOP])
      else $error("temperature shutdown lost");

   a_watchdog_flag: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && watchdog_fault |=> supply[GFS_BIT_WD])
      else $error("watchdog fault lost");

   a_reserved_bit: assert property (@(posedge ref_clk) disable iff (reset)
      supply[0] == 1'b0)
      else $error("reserved status bit set");

   a_variant_split: assert property (@(posedge ref_clk) disable iff (reset)
      (BRIDGES == 8) == (variant_code == GFS_CODE_EIGHT))
      else $error("variant code does not match bridges");

   a_fault_pin: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && fault_any |=> !fault_out_n)
      else $error("fault pin not driven");

   a_therm_summary: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && supply[GFS_BIT_TEMP_WARN] |=> thermal_watchdog_summary)
      else $error("thermal summary missing");

   a_link_ok_high: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && !frame_seen |=> link_ok)
      else $error("link ok low without frame fault");

   a_clear_works: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && flag_clear && gate_set[15:8] == 8'h00
      |=> gate_1_4 == 8'h00)
      else $error("clear left gate flags");

   a_gate_summary: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && (|gate_5_8) |=> any_fet_fault)
      else $error("gate flags missing from summary");

   a_reset_state: assert property (@(posedge ref_clk)
      reset |=> supply == GFS_STATUS_RESET && !frame_seen && fault_out_n)
      else $error("flags not cleared by reset");

   a_freeze_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !clk_en |=> $stable(supply) && $stable(rd_data))
      else $error("state moved while frozen");

   a_read_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !rd_en |=> $stable(rd_data))
      else $error("read data moved without read");

   a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && rd_en && addr == 6'h07 |=> rd_data == 8'h00)
      else $error("unmapped address read nonzero");
endmodule // gfs_status_regs

// ===== rtl/gfs_pkg.sv
// constants for the gate driver fault status register bank
// Summary of operation
// - address 3h holds gate faults of bridges 1-4, bit7 high 1 down to low 4
// - address 4h holds gate faults of bridges 5-8, bit7 high 5 down to low 8
// - address 5h bit 7 main supply undervoltage, bit 6 overvoltage
// - address 5h bit 5 charge pump undervoltage
// - address 5h bit 4 overtemperature warning, bit 3 overtemperature shutdown
// - address 5h bit 2 watchdog fault
// - address 5h bit 1 set when a frame has other than 16 clocks
// - frame length fault never drives the fault pin or its mirror
// - address 6h bits 3-0 variant code, bits 7-4 read zero
// - variant code differs between four and eight bridge parts
// - global bit 3 is OR of all drain-source and gate faults
// - global bit 7 reads 0 after any frame fault, else 1
// - global bit 0 is OR of thermal, watchdog and other warnings
package gfs_pkg;
   localparam logic [5:0] GFS_ADDR_GLOBAL = 6'h00;
   localparam logic [5:0] GFS_ADDR_GATE_1_4 = 6'h03;
   localparam logic [5:0] GFS_ADDR_GATE_5_8 = 6'h04;
   localparam logic [5:0] GFS_ADDR_SUPPLY = 6'h05;
   localparam logic [5:0] GFS_ADDR_VARIANT = 6'h06;
   localparam int GFS_BIT_SUPPLY_UV = 7;
   localparam int GFS_BIT_SUPPLY_OV = 6;
   localparam int GFS_BIT_PUMP_UV = 5;
   localparam int GFS_BIT_TEMP_WARN = 4;
   localparam int GFS_BIT_TEMP_STOP = 3;
   localparam int GFS_BIT_WD = 2;
   localparam int GFS_BIT_FRAME = 1;
   localparam int GFS_BIT_LINK_OK = 7;
   localparam int GFS_BIT_ANY_FET = 3;
   localparam int GFS_BIT_THERM_WD = 0;
   localparam int GFS_FRAME_CLOCKS = 16;
   localparam logic [7:0] GFS_STATUS_RESET = 8'h00;
   localparam logic [3:0] GFS_RESERVED_HI = 4'h0;
   // arbitrary neutral variant codes
   localparam logic [3:0] GFS_CODE_FOUR = 4'h1;
   localparam logic [3:0] GFS_CODE_EIGHT = 4'h2;
endpackage

// ===== bench/gfs_host.sv
// host model reading and writing the status registers
`timescale 1ns/1ps
module gfs_host
(
   input wire logic ref_clk,
   input wire logic [7:0] rd_data,
   output logic rd_en = 1'b0,
   output logic wr_en = 1'b0,
   output logic [5:0] addr = 6'h3F
);
   task automatic xfer(input logic w, logic [5:0] a, output logic [7:0] q);
      @(posedge ref_clk) #1 addr = a;
      rd_en = !w;
      wr_en = w;
      @(posedge ref_clk) #1 q = rd_data;
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = ~a;
   endtask
endmodule // gfs_host

// ===== bench/gfs_status_regs_tb.sv
// self-checking bench for the fault status register bank
`timescale 1ns/1ps
module gfs_status_regs_tb;
   import gfs_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, rd_en, wr_en, fo_n, th, af, link_ok;
   logic [15:0] gate = 16'h0000, g = 16'h0000, lfsr = 16'h000E;
   logic [7:0] ev = 8'h00, e = 8'h00, fcc = 8'h10, rd_data, q;
   logic [5:0] addr;
   int num_errors = 0, cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   gfs_status_regs #(.BRIDGES(8)) DUT (.ref_clk, .reset, .clk_en(1'b1),
      .gate_fault_in(gate), .ds_fault_in(16'h0000), .other_warning(1'b0),
      .main_supply_undervoltage(ev[7]), .main_supply_overvoltage(ev[6]),
      .charge_pump_undervoltage(ev[5]), .overtemp_warning(ev[4]),
      .overtemp_shutdown(ev[3]), .watchdog_fault(ev[2]), .frame_end(ev[1]),
      .frame_clock_count(fcc), .flag_clear(ev[0]), .rd_en, .wr_en, .addr,
      .wr_data(8'hFF), .rd_data, .fault_out_n(fo_n), .any_fet_fault(af),
      .thermal_watchdog_summary(th), .link_ok);
   gfs_host host (.ref_clk, .rd_data, .rd_en, .wr_en, .addr);
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] exp_reg(input int a);
      logic flt;
      flt = (|g) || (|(e & 8'hEC));
      return a == 0 ? {fcc == 8'h10 || !e[1], 1'b0, flt, 1'b0, |g, e[7],
         e[6], |(e & 8'h1C)} : a == 3 ? g[15:8] : a == 4 ? g[7:0] : a == 5 ?
         e & {6'h3F, fcc != 8'h10, 1'b0} :
         a == 6 ? {GFS_RESERVED_HI, GFS_CODE_EIGHT} : 8'h00;
   endfunction
   task automatic check(input logic [15:0] seen, exp);
      cmp_count++;
      num_errors += int'(seen !== exp);
      if (seen !== exp)
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
   endtask
   task automatic test_done;
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         for (int a = 0; a < 8; a++)
         begin
            host.xfer(1'b1, 6'(a), q);
            host.xfer(1'b0, 6'(a), q);
            check(q, exp_reg(a));
         end
         check({fo_n, th, af, link_ok},
            {!g && !(e & 8'hEC), |(e & 8'h1C), |g, fcc == 8'h10 || !e[1]});
         lfsr = nxt(lfsr);
         e = i % 7 ? 8'h01 << (i + 1) : 8'h02;
         g = i == 0 ? 16'h8001 : i == 7 ? 16'h0000 : lfsr;
         fcc = i == 7 ? 8'h0F : 8'h10;
         @(posedge ref_clk) #1 ev = e | 8'h01;
         gate = g;
         @(posedge ref_clk) #1 ev = 8'h00;
         gate = 16'h0000;
      end
      test_done();
   end
endmodule // gfs_status_regs_tb
